/* tb_uaps_top.sv */
// self-checking bench for the attach and power block
module tb_uaps_top
  import uaps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 40;
  logic clk = 1'b0;
  logic rst = 1'b1;
  uaps_apb_req_t req = '0;
  uaps_apb_rsp_t rsp;
  logic vsup = 1'b0, vsen = 1'b0, wake = 1'b0, rxa = 1'b0, txa = 1'b0, susp = 1'b0;
  logic mute = 1'b0;
  uaps_chg_t kind = UAPS_CHG_SDP;
  uaps_chg_t res;
  logic vld, start, pull, rwk, sout, s_oe, cb0, cb1, c_oe, pg, pg_oe, la, la_oe, lb, lb_oe;
  int n_fail = 0;
  int checks = 0;
  int n_start = 0;
  logic [31:0] rd;
  logic err;

  always #10 clk = ~clk;
  always @(posedge clk)
    if (start === 1'b1)
      n_start <= n_start + 1;

  uaps_top #(.FILT_CYC(4), .DETECT_CYC(20), .WAKE_CYC(10)) u_uaps_top (
    .clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp), .vbus_supply_in(vsup), .vbus_sense_in(vsen),
    .wakeup_in(wake), .usb_rx_active(rxa), .usb_tx_active(txa), .usb_bus_suspended(susp), .chg_result(res),
    .chg_result_valid(vld), .chg_detect_start(start), .dplus_pullup_en(pull), .remote_wakeup(rwk),
    .suspend_out(sout), .suspend_oe_n(s_oe), .charger_type_bit0(cb0), .charger_type_bit1(cb1),
    .charger_oe_n(c_oe), .power_gate_n(pg), .power_gate_oe_n(pg_oe), .led_pin_a(la), .led_pin_a_oe_n(la_oe),
    .led_pin_b(lb), .led_pin_b_oe_n(lb_oe));
  uaps_partner u_uaps_partner (.clk(clk), .rst(rst), .chg_detect_start(start), .kind(kind), .mute(mute),
    .chg_result(res), .chg_result_valid(vld));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 50);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    chk("pready", 32'h1, rsp.pready);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", n_fail, checks);
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    wait_n(20000);
    n_fail++;
    finish_test();
  end

  initial
  begin
    wait_n(8);
    chk("oe_n", 32'h1f, {s_oe, c_oe, pg_oe, la_oe, lb_oe});
    wait_n(8);
    rst <= 1'b0;
    apb(1'b0, UAPS_CODE_OFF, '0);
    chk("code", 32'he4, rd);
    apb(1'b0, UAPS_CFG_OFF, '0);
    chk("cfg", 32'h0, rd);
    apb(1'b0, 12'h010, '0);
    chk("unmapped", 32'h0, rd);
    chk("slverr", 32'h1, err);
    // activity and vbus before configuration is loaded
    rxa <= 1'b1;
    vsup <= 1'b1;
    wait_n(SETTLE);
    chk("leds", 32'h3, {la, lb});
    chk("gate", 32'h1, pg);
    chk("pull", 32'h0, pull);
    rxa <= 1'b0;
    vsup <= 1'b0;
    wait_n(SETTLE);
    apb(1'b1, UAPS_CFG_OFF, 32'h1);
    apb(1'b1, UAPS_CODE_OFF, 32'h1b);
    vsup <= 1'b1;
    wait_n(SETTLE);
    chk("pull", 32'h1, pull);
    chk("type", 32'h2, {cb1, cb0});
    chk("starts", 32'h0, n_start);
    vsup <= 1'b0;
    wait_n(SETTLE);
    chk("pull", 32'h0, pull);
    chk("type", 32'h3, {cb1, cb0});
    apb(1'b1, UAPS_CODE_OFF, 32'he4);
    apb(1'b1, UAPS_CFG_OFF, 32'h3);
    for (int k = 1; k < 4; k++)
    begin
      kind <= uaps_chg_t'(k);
      n_start = 0;
      vsup <= 1'b1;
      wait_n(SETTLE);
      chk("starts", 32'h1, n_start);
      chk("pull", 32'(k != 3), pull);
      chk("type", (k == 1) ? 32'h1 : 32'h2, {cb1, cb0});
      vsup <= 1'b0;
      wait_n(SETTLE);
      chk("type", 32'h0, {cb1, cb0});
    end
    // detector that never answers: timeout falls back to a standard port
    mute <= 1'b1;
    vsup <= 1'b1;
    wait_n(SETTLE);
    chk("pull", 32'h1, pull);
    chk("type", 32'h1, {cb1, cb0});
    mute <= 1'b0;
    vsup <= 1'b0;
    wait_n(SETTLE);
    chk("type", 32'h0, {cb1, cb0});
    n_start = 0;
    vsup <= 1'b1;
    wait_n(2);
    vsup <= 1'b0;
    wait_n(SETTLE);
    chk("pull", 32'h0, pull);
    chk("starts", 32'h0, n_start);
    apb(1'b1, UAPS_CFG_OFF, 32'h5);
    vsup <= 1'b1;
    wait_n(SETTLE);
    chk("pull", 32'h0, pull);
    vsen <= 1'b1;
    vsup <= 1'b0;
    wait_n(SETTLE);
    chk("pull", 32'h1, pull);
    apb(1'b0, UAPS_STAT_OFF, '0);
    chk("stat", 32'h37, rd);
    chk("slverr", 32'h0, err);
    // led a on receive, led b on transmit, gate pin on
    apb(1'b1, UAPS_CFG_OFF, 32'h9d);
    apb(1'b1, UAPS_USB_OFF, 32'h1);
    wait_n(3);
    chk("gate", 32'h0, pg);
    chk("oe_n", 32'h08, {s_oe, c_oe, pg_oe, la_oe, lb_oe});
    rxa <= 1'b1;
    wait_n(3);
    chk("leds", 32'h1, {la, lb});
    rxa <= 1'b0;
    txa <= 1'b1;
    wait_n(3);
    chk("leds", 32'h2, {la, lb});
    apb(1'b1, UAPS_CFG_OFF, 32'hbd);
    wait_n(2);
    chk("led_a", 32'h0, la);
    txa <= 1'b0;
    rxa <= 1'b1;
    wait_n(3);
    chk("led_a", 32'h0, la);
    rxa <= 1'b0;
    susp <= 1'b1;
    wait_n(4);
    chk("suspend", 32'h1, sout);
    chk("gate", 32'h1, pg);
    chk("type", 32'h3, {cb1, cb0});
    wake <= 1'b1;
    for (int i = 0; i < 20 && rwk !== 1'b1; i++)
      @(posedge clk);
    chk("wakeup", 32'h1, rwk);
    wake <= 1'b0;
    susp <= 1'b0;
    wait_n(SETTLE);
    chk("wakeup", 32'h0, rwk);
    finish_test();
  end
endmodule

/* uaps_led_mux.sv */
// one activity led pin: selects rx, tx or both and drives active low
module uaps_led_mux
  import uaps_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic loaded,
  input wire uaps_led_t sel,
  input wire logic rx_act,
  input wire logic tx_act,
  output logic led_n
);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      led_n <= 1'b1;
    else if (!loaded)
      led_n <= 1'b1;
    else
    begin
      case (sel)
        UAPS_LED_RX: led_n <= !rx_act;
        UAPS_LED_TX: led_n <= !tx_act;
        UAPS_LED_ANY: led_n <= !(rx_act || tx_act);
        default: led_n <= 1'b1;
      endcase
    end
  end
endmodule

/* uaps_partner.sv */
// charger detector model answering a detect start
module uaps_partner
  import uaps_pkg::*;
#(
  parameter int DLY = 5
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic chg_detect_start,
  input wire uaps_chg_t kind,
  input wire logic mute,
  output uaps_chg_t chg_result,
  output logic chg_result_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      cnt <= 8'h00;
      chg_result_valid <= 1'b0;
      chg_result <= UAPS_CHG_NONE;
    end
    else
    begin
      chg_result_valid <= 1'b0;
      // result lines undefined outside the answer
      chg_result <= uaps_chg_t'(~chg_result);
      if (chg_detect_start)
        cnt <= 8'(DLY);
      else if (cnt == 8'h01)
      begin
        // a muted detector never answers, so the block must time out
        chg_result_valid <= !mute;
        chg_result <= kind;
        cnt <= 8'h00;
      end
      else if (cnt != 8'h00)
        cnt <= cnt - 8'h01;
    end
endmodule

/* uaps_pkg.sv */
// shared constants, types and register map of the attach and power block
package uaps_pkg;
  // apb register byte offsets
  localparam logic [11:0] UAPS_CFG_OFF = 12'h000;
  localparam logic [11:0] UAPS_CODE_OFF = 12'h004;
  localparam logic [11:0] UAPS_USB_OFF = 12'h008;
  localparam logic [11:0] UAPS_STAT_OFF = 12'h00c;
  // config field positions
  localparam int UAPS_CFG_LOADED = 0;
  localparam int UAPS_CFG_BCD_EN = 1;
  localparam int UAPS_CFG_SENSE_EN = 2;
  localparam int UAPS_CFG_PGATE_EN = 3;
  localparam int UAPS_CFG_LEDA_LSB = 4;
  localparam int UAPS_CFG_LEDB_LSB = 6;
  // usb state register field positions
  localparam int UAPS_USB_CONFIGURED = 0;
  localparam int UAPS_USB_SUSPENDED = 1;
  localparam int UAPS_USB_CHG_DONE = 2;
  localparam int UAPS_USB_CHG_LSB = 3;
  // reset values
  localparam logic [31:0] UAPS_CFG_RST = 32'h0000_0000;
  localparam logic [7:0] UAPS_CODE_RST = 8'he4;
  localparam logic [31:0] UAPS_USB_RST = 32'h0000_0000;
  // timing
  localparam int UAPS_CLK_HZ = 50_000_000;
  localparam int UAPS_FILT_US = 10;
  localparam int UAPS_FILT_CYC = (UAPS_FILT_US * (UAPS_CLK_HZ / 1_000_000));
  localparam int UAPS_DETECT_US = 100;
  localparam int UAPS_DETECT_CYC = (UAPS_DETECT_US * (UAPS_CLK_HZ / 1_000_000));
  localparam int UAPS_WAKE_US = 2000;
  localparam int UAPS_WAKE_CYC = (UAPS_WAKE_US * (UAPS_CLK_HZ / 1_000_000));

  typedef enum logic [1:0] {UAPS_CHG_NONE, UAPS_CHG_SDP, UAPS_CHG_CDP, UAPS_CHG_DCP} uaps_chg_t;
  typedef enum logic [1:0] {UAPS_LED_OFF, UAPS_LED_RX, UAPS_LED_TX, UAPS_LED_ANY} uaps_led_t;

  typedef struct packed {
    logic [1:0] state_code_suspend;
    logic [1:0] state_code_fast;
    logic [1:0] state_code_sdp;
    logic [1:0] state_code_none;
  } uaps_code_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } uaps_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } uaps_apb_rsp_t;
endpackage

/* uaps_sync_filter.sv */
// two-flop synchroniser followed by a stable-count filter
module uaps_sync_filter
  import uaps_pkg::*;
#(
  parameter int FILT_CYC = UAPS_FILT_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic async_in,
  output logic filtered
);
  localparam int CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] CMAX = CW'(FILT_CYC);
  logic meta;
  logic synced;
  logic [CW-1:0] count;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= 1'b0;
      synced <= 1'b0;
    end
    else
    begin
      meta <= async_in;
      synced <= meta;
    end
  end

  // output follows only after the input held steady for FILT_CYC + 1 cycles
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count <= '0;
      filtered <= 1'b0;
    end
    else if (synced == filtered)
      count <= '0;
    else if (count == CMAX)
    begin
      count <= '0;
      filtered <= synced;
    end
    else
      count <= count + CW'(1);
  end
endmodule

/* uaps_top.sv */
// attach, charger indication and power signalling block with apb registers
module uaps_top
  import uaps_pkg::*;
#(
  parameter int FILT_CYC = UAPS_FILT_CYC,
  parameter int DETECT_CYC = UAPS_DETECT_CYC,
  parameter int WAKE_CYC = UAPS_WAKE_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire uaps_apb_req_t apb_req,
  output uaps_apb_rsp_t apb_rsp,
  input wire logic vbus_supply_in,
  input wire logic vbus_sense_in,
  input wire logic wakeup_in,
  input wire logic usb_rx_active,
  input wire logic usb_tx_active,
  input wire logic usb_bus_suspended,
  input wire uaps_chg_t chg_result,
  input wire logic chg_result_valid,
  output logic chg_detect_start,
  output logic dplus_pullup_en,
  output logic remote_wakeup,
  output logic suspend_out,
  output logic suspend_oe_n,
  output logic charger_type_bit0,
  output logic charger_type_bit1,
  output logic charger_oe_n,
  output logic power_gate_n,
  output logic power_gate_oe_n,
  output logic led_pin_a,
  output logic led_pin_a_oe_n,
  output logic led_pin_b,
  output logic led_pin_b_oe_n
);
  localparam int DW = $clog2(DETECT_CYC + 1);
  localparam int WW = $clog2(WAKE_CYC + 1);
  localparam logic [DW-1:0] DMAX = DW'(DETECT_CYC);
  localparam logic [WW-1:0] WMAX = WW'(WAKE_CYC);

  typedef enum {UAPS_ST_DETACHED, UAPS_ST_DETECT, UAPS_ST_ATTACHED, UAPS_ST_CHARGE_ONLY} uaps_state_t;

  logic [31:0] cfg;
  uaps_code_t code_map;
  logic [31:0] usb_ctl;
  uaps_state_t state;
  uaps_chg_t chg_type;
  logic chg_done;
  logic [DW-1:0] det_count;
  logic [WW-1:0] wake_count;
  logic sense_filt;
  logic supply_filt;
  logic wake_filt;
  logic wake_prev;
  logic vbus_present;
  logic vbus_prev;
  logic loaded;
  logic led_a_n;
  logic led_b_n;
  logic [1:0] code_out;
  logic apb_access;
  logic apb_wr;
  logic [31:0] next_rdata;
  logic [31:0] read_data;

  assign loaded = cfg[UAPS_CFG_LOADED];

  // supply pin and sense pin are both asynchronous to clk
  uaps_sync_filter #(.FILT_CYC(FILT_CYC)) u_sense_filt (
    .clk(clk),
    .rst(rst),
    .async_in(vbus_sense_in),
    .filtered(sense_filt)
  );

  uaps_sync_filter #(.FILT_CYC(FILT_CYC)) u_supply_filt (
    .clk(clk),
    .rst(rst),
    .async_in(vbus_supply_in),
    .filtered(supply_filt)
  );

  uaps_sync_filter #(.FILT_CYC(1)) u_wake_sync (
    .clk(clk),
    .rst(rst),
    .async_in(wakeup_in),
    .filtered(wake_filt)
  );

  // sense pin only counts once configuration enables it
  assign vbus_present = (loaded && cfg[UAPS_CFG_SENSE_EN]) ? sense_filt : supply_filt;

  // apb slave, zero wait states
  assign apb_access = apb_req.psel && apb_req.penable;
  assign apb_wr = apb_access && apb_req.pwrite;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg <= UAPS_CFG_RST;
      code_map <= UAPS_CODE_RST;
      usb_ctl <= UAPS_USB_RST;
    end
    else if (apb_wr)
    begin
      case (apb_req.paddr)
        UAPS_CFG_OFF: cfg <= {24'h000000, apb_req.pwdata[7:0]};
        UAPS_CODE_OFF: code_map <= apb_req.pwdata[7:0];
        UAPS_USB_OFF: usb_ctl <= {30'h0, apb_req.pwdata[1:0]};
        default: ;
      endcase
    end
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (apb_req.paddr)
      UAPS_CFG_OFF: next_rdata = cfg;
      UAPS_CODE_OFF: next_rdata = {24'h000000, code_map};
      UAPS_USB_OFF: next_rdata = usb_ctl;
      UAPS_STAT_OFF: next_rdata = {24'h000000, remote_wakeup, suspend_out, dplus_pullup_en, vbus_present,
                                   chg_type, chg_done, loaded};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // read data captured in the setup cycle, held through the access phase
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      read_data <= 32'h0000_0000;
    else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
      read_data <= next_rdata;
  end

  // whole response driven in one place, no wait states
  assign apb_rsp = '{pready: 1'b1,
                     pslverr: apb_access && (apb_req.paddr[11:4] != 8'h00 || apb_req.paddr[1:0] != 2'b00),
                     prdata: read_data};

  // attach and charger detection sequence
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= UAPS_ST_DETACHED;
      chg_type <= UAPS_CHG_NONE;
      chg_done <= 1'b0;
      det_count <= '0;
      vbus_prev <= 1'b0;
      chg_detect_start <= 1'b0;
    end
    else
    begin
      vbus_prev <= vbus_present;
      chg_detect_start <= 1'b0;
      if (!vbus_present)
      begin
        state <= UAPS_ST_DETACHED;
        chg_type <= UAPS_CHG_NONE;
        chg_done <= 1'b0;
        det_count <= '0;
      end
      else
      begin
        case (state)
          UAPS_ST_DETACHED:
          begin
            if (loaded && vbus_present && !vbus_prev)
            begin
              if (cfg[UAPS_CFG_BCD_EN])
              begin
                state <= UAPS_ST_DETECT;
                chg_detect_start <= 1'b1;
                det_count <= '0;
              end
              else
              begin
                state <= UAPS_ST_ATTACHED;
                chg_type <= UAPS_CHG_SDP;
                chg_done <= 1'b1;
              end
            end
          end
          UAPS_ST_DETECT:
          begin
            if (chg_result_valid || det_count == DMAX)
            begin
              // missing result falls back to a standard port
              chg_type <= chg_result_valid ? chg_result : UAPS_CHG_SDP;
              chg_done <= 1'b1;
              if (chg_result_valid && chg_result == UAPS_CHG_DCP)
                state <= UAPS_ST_CHARGE_ONLY;
              else
                state <= UAPS_ST_ATTACHED;
            end
            else
              det_count <= det_count + DW'(1);
          end
          UAPS_ST_ATTACHED: ;
          UAPS_ST_CHARGE_ONLY: ;
          default: state <= UAPS_ST_DETACHED;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      dplus_pullup_en <= 1'b0;
    else
      dplus_pullup_en <= vbus_present && (state == UAPS_ST_ATTACHED);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      suspend_out <= 1'b0;
    else
      suspend_out <= usb_bus_suspended && (state == UAPS_ST_ATTACHED);
  end

  // wakeup edge while suspended starts a fixed-length remote wakeup
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wake_prev <= 1'b0;
      wake_count <= '0;
      remote_wakeup <= 1'b0;
    end
    else
    begin
      wake_prev <= wake_filt;
      if (remote_wakeup)
      begin
        if (wake_count == WMAX)
        begin
          remote_wakeup <= 1'b0;
          wake_count <= '0;
        end
        else
          wake_count <= wake_count + WW'(1);
      end
      else if (wake_filt && !wake_prev && suspend_out)
        remote_wakeup <= 1'b1;
    end
  end

  always_comb
  begin
    code_out = code_map.state_code_none;
    if (!chg_done)
      code_out = code_map.state_code_none;
    else if (suspend_out)
      code_out = code_map.state_code_suspend;
    else
    begin
      case (chg_type)
        UAPS_CHG_SDP: code_out = code_map.state_code_sdp;
        UAPS_CHG_CDP: code_out = code_map.state_code_fast;
        UAPS_CHG_DCP: code_out = code_map.state_code_fast;
        default: code_out = code_map.state_code_none;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      charger_type_bit0 <= 1'b0;
      charger_type_bit1 <= 1'b0;
    end
    else
    begin
      charger_type_bit0 <= code_out[0];
      charger_type_bit1 <= code_out[1];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      power_gate_n <= 1'b1;
    else
      power_gate_n <= !(loaded && usb_ctl[UAPS_USB_CONFIGURED] && !suspend_out);
  end

  uaps_led_mux u_led_a (
    .clk(clk),
    .rst(rst),
    .loaded(loaded),
    .sel(uaps_led_t'(cfg[UAPS_CFG_LEDA_LSB +: 2])),
    .rx_act(usb_rx_active),
    .tx_act(usb_tx_active),
    .led_n(led_a_n)
  );

  uaps_led_mux u_led_b (
    .clk(clk),
    .rst(rst),
    .loaded(loaded),
    .sel(uaps_led_t'(cfg[UAPS_CFG_LEDB_LSB +: 2])),
    .rx_act(usb_rx_active),
    .tx_act(usb_tx_active),
    .led_n(led_b_n)
  );

  assign led_pin_a = led_a_n;
  assign led_pin_b = led_b_n;

  // pins float during reset and until configuration says they are used
  assign suspend_oe_n = rst || !loaded;
  assign charger_oe_n = rst || !(loaded && cfg[UAPS_CFG_BCD_EN]);
  assign power_gate_oe_n = rst || !(loaded && cfg[UAPS_CFG_PGATE_EN]);
  assign led_pin_a_oe_n = rst || !(loaded && cfg[UAPS_CFG_LEDA_LSB +: 2] != 2'b00);
  assign led_pin_b_oe_n = rst || !(loaded && cfg[UAPS_CFG_LEDB_LSB +: 2] != 2'b00);
endmodule

/* uaps_top_asserts.sv */
// port assertions for the attach and power block
module uaps_top_asserts
  import uaps_pkg::*;
#(
  parameter int FILT_CYC = UAPS_FILT_CYC,
  parameter int WAKE_CYC = UAPS_WAKE_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic vbus_supply_in,
  input wire logic vbus_sense_in,
  input wire logic usb_rx_active,
  input wire logic usb_tx_active,
  input wire logic usb_bus_suspended,
  input wire logic chg_detect_start,
  input wire logic dplus_pullup_en,
  input wire logic remote_wakeup,
  input wire logic suspend_out,
  input wire logic power_gate_n,
  input wire logic led_pin_a,
  input wire logic led_pin_b,
  input wire logic charger_oe_n,
  input wire logic led_pin_a_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] lo_cnt;
  logic [31:0] wk_len;
  logic vb_any;
  assign vb_any = vbus_supply_in || vbus_sense_in;
  // cycles with both vbus inputs low
  always_ff @(posedge clk or posedge rst)
    if (rst)
      lo_cnt <= 16'h0000;
    else if (vb_any)
      lo_cnt <= 16'h0000;
    else if (lo_cnt != 16'hffff)
      lo_cnt <= lo_cnt + 16'h0001;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      wk_len <= 32'h0000_0000;
    else
      wk_len <= remote_wakeup ? wk_len + 32'h0000_0001 : 32'h0000_0000;
  sequence s_idle;
    !(usb_rx_active || usb_tx_active);
  endsequence
  sequence s_susp2;
    suspend_out ##1 suspend_out;
  endsequence
  a_reset_float: assert property (@(posedge clk) rst |-> charger_oe_n && led_pin_a_oe_n)
    else $error("pin driven in reset");
  a_start_pulse: assert property (@(posedge clk) disable iff (rst) chg_detect_start |=> !chg_detect_start)
    else $error("start not a pulse");
  a_start_no_pull: assert property (@(posedge clk) disable iff (rst) chg_detect_start |-> !dplus_pullup_en)
    else $error("pullup on at detect start");
  a_vbus_gone: assert property (@(posedge clk) disable iff (rst) int'(lo_cnt) > FILT_CYC + 6 |-> !dplus_pullup_en)
    else $error("pullup on without vbus");
  a_pull_cause: assert property (@(posedge clk) disable iff (rst) $rose(dplus_pullup_en) |-> $past(vb_any, 3))
    else $error("pullup rose without vbus");
  a_wake_len: assert property (@(posedge clk) disable iff (rst) $fell(remote_wakeup) |-> int'(wk_len) == WAKE_CYC + 1)
    else $error("wakeup length wrong");
  a_wake_cause: assert property (@(posedge clk) disable iff (rst) $rose(remote_wakeup) |-> $past(suspend_out))
    else $error("wakeup while not suspended");
  a_susp_follow: assert property (@(posedge clk) disable iff (rst) suspend_out |-> $past(usb_bus_suspended))
    else $error("suspend without bus suspend");
  a_gate_susp: assert property (@(posedge clk) disable iff (rst) s_susp2 |-> power_gate_n)
    else $error("power gate on in suspend");
  a_led_idle: assert property (@(posedge clk) disable iff (rst) s_idle ##1 s_idle |-> led_pin_a && led_pin_b)
    else $error("led lit while idle");
endmodule

bind uaps_top uaps_top_asserts #(.FILT_CYC(FILT_CYC), .WAKE_CYC(WAKE_CYC)) u_uaps_top_asserts (
  .clk(clk), .rst(rst), .vbus_supply_in(vbus_supply_in), .vbus_sense_in(vbus_sense_in),
  .usb_rx_active(usb_rx_active), .usb_tx_active(usb_tx_active), .usb_bus_suspended(usb_bus_suspended),
  .chg_detect_start(chg_detect_start), .dplus_pullup_en(dplus_pullup_en), .remote_wakeup(remote_wakeup),
  .suspend_out(suspend_out), .power_gate_n(power_gate_n), .led_pin_a(led_pin_a), .led_pin_b(led_pin_b),
  .charger_oe_n(charger_oe_n), .led_pin_a_oe_n(led_pin_a_oe_n));
